/* File: arsc_ctl.sv */
// Converter sequencer, result pair and sleep handling
// Operation
// - Completion writes 10-bit result into pair
// - Justify select places result left or right
// - Unused six result bits load as zero
// - Converter off: result bytes are plain registers
// - Sleep conversion only with RC clock
// - RC clock delays start one instruction cycle
// - Completion clears start bit, loads result
// - Completion sets done flag regardless of enable
// - Sleep completion with enable wakes device
// - Sleep completion without enable powers down
// - Sleep with oscillator clock aborts, powers down
// - Reset clears control, powers off, aborts
// - Power-on reset leaves result pair unknown
// - Hold capacitor disconnects 100 ns after start
// - First code step at one LSB
// - Clearing start aborts, result kept
// - After a start-clear abort wait two bit periods
// - Clock select picks 2/8/32 osc or RC
// - Conversion lasts eleven and a half periods
`timescale 1ns/10ps
module arsc_ctl
  import arsc_pkg::*;
(
  input wire logic clk_i,                     // Oscillator clock, 200 MHz
  input wire logic reset_i,                   // Synchronous device reset
  input wire logic ctl_wr_i,                  // Control write strobe
  input wire logic converter_on_i,            // Control write data: converter on
  input wire logic [1:0] conv_clock_select_i, // Control write data: clock select
  input wire logic result_justify_select_i,   // Control write data: 1 right, 0 left
  input wire logic conv_done_irq_enable_i,    // Control write data: done irq enable
  input wire logic go_set_i,                  // Software sets start bit
  input wire logic go_clear_i,                // Software clears start bit
  input wire logic flag_clear_i,              // Software clears done flag
  input wire logic res_hi_wr_i,               // High result byte write strobe
  input wire logic res_lo_wr_i,               // Low result byte write strobe
  input wire logic [7:0] wdata_i,             // Result byte write data
  input wire logic sleep_i,                   // Device is in sleep
  input wire logic rc_tick_i,                 // Half period tick of RC clock
  input wire logic comparator_i,              // Input at or above trial level
  output logic converter_on_o,                // Converter on bit
  output logic [1:0] conv_clock_select_o,     // Clock select field
  output logic result_justify_select_o,       // Justify select bit
  output logic conv_done_irq_enable_o,        // Done irq enable bit
  output logic go_done_o,                     // Start/done bit
  output logic conv_done_flag_o,              // Done flag
  output logic wake_o,                        // Wake request pulse
  output logic converter_powered_o,           // Analog section powered
  output logic hold_connected_o,              // Hold capacitor on input
  output logic [RESULT_W-1:0] dac_code_o,     // Trial code for comparator
  output logic [7:0] result_high_byte_o,      // Result pair high byte
  output logic [7:0] result_low_byte_o        // Result pair low byte
);
  arsc_tick_if tk ();
  arsc_state_e state, next_state;
  logic on, next_on, fmt, next_fmt, ie, next_ie, go, next_go, flag, next_flag;
  logic sleep_pd, next_sleep_pd, hold, next_hold, wake, next_wake, pwr, next_pwr;
  logic [1:0] csel, next_csel;
  logic [4:0] disc_cnt, next_disc_cnt, half_cnt, next_half_cnt, n;
  logic [2:0] dly_cnt, next_dly_cnt;
  logic [RESULT_W-1:0] sar, next_sar, dac, next_dac;
  logic [3:0] idx, next_idx;
  logic done_evt, busy, abort_sleep;
  logic [15:0] load_val;

  arsc_bit_timer u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tk(tk)
  );

  // Timer runs only while conversion or the wait after completion or abort is in progress
  assign tk.run = (state == ST_CONV) || (state == ST_WAIT);
  assign tk.csel = csel;
  assign tk.rc_tick = rc_tick_i;
  assign busy = (state == ST_DELAY) || (state == ST_CONV);
  assign abort_sleep = sleep_i && (csel != CSEL_RC) && on;
  // Justified result with zero padding
  assign load_val = fmt ? {{PAD_W{1'b0}}, sar} : {sar, {PAD_W{1'b0}}};

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_on = on;
    next_csel = csel;
    next_fmt = fmt;
    next_ie = ie;
    next_go = go;
    next_flag = flag;
    next_sleep_pd = sleep_pd;
    next_wake = 1'b0;
    next_disc_cnt = disc_cnt;
    next_half_cnt = half_cnt;
    next_dly_cnt = dly_cnt;
    next_sar = sar;
    next_idx = idx;
    done_evt = 1'b0;
    n = half_cnt + 5'h01;
    if (ctl_wr_i) begin
      next_on = converter_on_i;
      next_csel = conv_clock_select_i;
      next_fmt = result_justify_select_i;
      next_ie = conv_done_irq_enable_i;
    end
    if (flag_clear_i) begin
      next_flag = 1'b0;
    end
    // Power-down latch follows sleep; the on bit itself is never touched
    if (!sleep_i) begin
      next_sleep_pd = 1'b0;
    end else if (abort_sleep) begin
      next_sleep_pd = 1'b1;
    end
    if (busy && (disc_cnt != HOLD_DISC_CYC)) begin
      next_disc_cnt = disc_cnt + 5'h01;
    end
    case (state)
      ST_IDLE: begin
        if (go_set_i && on && !sleep_pd) begin
          next_go = 1'b1;
          next_disc_cnt = 5'h00;
          next_half_cnt = 5'h00;
          next_dly_cnt = 3'h0;
          next_sar = '0;
          next_idx = MSB_IDX;
          // Lets the sleep instruction retire before conversion noise starts
          next_state = (csel == CSEL_RC) ? ST_DELAY : ST_CONV;
        end
      end
      ST_DELAY: begin
        next_dly_cnt = dly_cnt + 3'h1;
        if (dly_cnt == INSTR_CYC - 3'h1) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (tk.half_tick && !hold) begin
          next_half_cnt = n;
          if (n >= FIRST_BIT_HALF && n <= LAST_BIT_HALF && n[0]) begin
            // Keep trial bit when input reaches trial level
            next_sar[idx] = comparator_i;
            next_idx = idx - 4'h1;
          end
          if (n == CONV_HALVES) begin
            done_evt = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (tk.half_tick) begin
          next_half_cnt = n;
          if (n == WAIT_HALVES) begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Completion: all effects in one edge, flag set wins over clear
    if (done_evt) begin
      next_go = 1'b0;
      next_flag = 1'b1;
      next_half_cnt = 5'h00;
      next_state = ST_WAIT;
      if (sleep_i && ie) begin
        next_wake = 1'b1;
      end else if (sleep_i) begin
        next_sleep_pd = 1'b1;
      end
    end
    // Aborts: software clear waits two periods; power loss goes straight idle
    if (busy && !done_evt) begin
      if (!on || abort_sleep) begin
        next_go = 1'b0;
        next_state = ST_IDLE;
      end else if (go_clear_i) begin
        next_go = 1'b0;
        next_half_cnt = 5'h00;
        next_state = ST_WAIT;
      end
    end
    next_pwr = next_on && !next_sleep_pd;
    case (next_state)
      ST_IDLE: next_hold = next_pwr;
      ST_WAIT: next_hold = 1'b0;
      default: next_hold = next_disc_cnt != HOLD_DISC_CYC;
    endcase
    next_dac = next_sar;
    // Index wraps past the last bit; no trial bit is shown once all bits are resolved
    if (next_state == ST_CONV && next_idx <= MSB_IDX) begin
      next_dac[next_idx] = 1'b1;
    end
  end

  // Control and sequencer registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      on <= 1'b0;
      csel <= CSEL_RST;
      fmt <= 1'b0;
      ie <= 1'b0;
      go <= 1'b0;
      flag <= 1'b0;
      sleep_pd <= 1'b0;
      wake <= 1'b0;
      pwr <= 1'b0;
      hold <= 1'b0;
      disc_cnt <= 5'h00;
      half_cnt <= 5'h00;
      dly_cnt <= 3'h0;
      sar <= '0;
      idx <= MSB_IDX;
      dac <= '0;
    end else begin
      state <= next_state;
      on <= next_on;
      csel <= next_csel;
      fmt <= next_fmt;
      ie <= next_ie;
      go <= next_go;
      flag <= next_flag;
      sleep_pd <= next_sleep_pd;
      wake <= next_wake;
      pwr <= next_pwr;
      hold <= next_hold;
      disc_cnt <= next_disc_cnt;
      half_cnt <= next_half_cnt;
      dly_cnt <= next_dly_cnt;
      sar <= next_sar;
      idx <= next_idx;
      dac <= next_dac;
    end
  end

  // Result pair carries no reset so its power-on content is undefined
  always_ff @(posedge clk_i) begin
    if (done_evt) begin
      {result_high_byte_o, result_low_byte_o} <= load_val;
    end else begin
      if (res_hi_wr_i && !on) begin
        result_high_byte_o <= wdata_i;
      end
      if (res_lo_wr_i && !on) begin
        result_low_byte_o <= wdata_i;
      end
    end
  end

  assign converter_on_o = on;
  assign conv_clock_select_o = csel;
  assign result_justify_select_o = fmt;
  assign conv_done_irq_enable_o = ie;
  assign go_done_o = go;
  assign conv_done_flag_o = flag;
  assign wake_o = wake;
  assign converter_powered_o = pwr;
  assign hold_connected_o = hold;
  assign dac_code_o = dac;

  AST_RESULT_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
    done_evt |=> {result_high_byte_o, result_low_byte_o} == $past(load_val))
    else $error("result pair not loaded on completion");
  AST_PAD_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    done_evt && fmt |=> result_high_byte_o[7:2] == 6'h00)
    else $error("right justified result has nonzero pad");
  AST_DONE_ATOMIC: assert property (@(posedge clk_i) disable iff (reset_i)
    done_evt |=> !go_done_o && conv_done_flag_o && state == ST_WAIT)
    else $error("completion effects not in one cycle");
  AST_FLAG_SET_WINS: assert property (@(posedge clk_i) disable iff (reset_i)
    done_evt && flag_clear_i && !ie |=> conv_done_flag_o)
    else $error("done flag lost or gated by enable");
  AST_RC_DELAY: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(go_done_o) && csel == CSEL_RC |-> state == ST_DELAY [*4])
    else $error("RC start not delayed one instruction cycle");
  AST_SLEEP_ABORT: assert property (@(posedge clk_i) disable iff (reset_i)
    busy && abort_sleep && !ctl_wr_i && !done_evt
    |=> state == ST_IDLE && !go_done_o && converter_on_o && !converter_powered_o)
    else $error("sleep with oscillator clock did not abort");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (reset_i)
    done_evt && sleep_i && ie |=> wake_o ##1 !wake_o)
    else $error("no wake pulse on sleep completion");
  AST_SLEEP_PD: assert property (@(posedge clk_i) disable iff (reset_i)
    done_evt && sleep_i && !ie && !ctl_wr_i |=> !converter_powered_o && converter_on_o)
    else $error("converter not powered down after sleep completion");
  AST_ABORT_KEEP: assert property (@(posedge clk_i) disable iff (reset_i)
    state == ST_CONV && go_clear_i && on && !abort_sleep && !done_evt && !ctl_wr_i
    |=> state == ST_WAIT && $stable({result_high_byte_o, result_low_byte_o}))
    else $error("abort changed result or skipped wait");
  AST_HOLD_DISC: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(go_done_o) |-> ##[19:20] (!hold_connected_o || !go_done_o))
    else $error("hold capacitor not disconnected in time");
  COV_DONE: cover property (@(posedge clk_i) disable iff (reset_i) done_evt);
  COV_ABORT: cover property (@(posedge clk_i) disable iff (reset_i)
    state == ST_CONV && go_clear_i);
  COV_WAKE: cover property (@(posedge clk_i) disable iff (reset_i) wake_o);
  COV_SLEEP_ABORT: cover property (@(posedge clk_i) disable iff (reset_i)
    busy && abort_sleep);
endmodule

/* File: arsc_pkg.sv */
// Shared constants and types for the converter result and sleep control block
package arsc_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int HOLD_DISC_NS = 100;
  localparam logic [4:0] HOLD_DISC_CYC = 5'((HOLD_DISC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] INSTR_CYC = 3'h4; // One instruction cycle in oscillator periods
  // Conversion clock select codes
  localparam logic [1:0] CSEL_2OSC = 2'h0;
  localparam logic [1:0] CSEL_8OSC = 2'h1;
  localparam logic [1:0] CSEL_32OSC = 2'h2;
  localparam logic [1:0] CSEL_RC = 2'h3;
  // Half bit period terminal counts (half period minus one, in oscillator periods)
  localparam logic [3:0] HALF_TERM_2OSC = 4'h0;
  localparam logic [3:0] HALF_TERM_8OSC = 4'h3;
  localparam logic [3:0] HALF_TERM_32OSC = 4'hf;
  // Sequence lengths in half bit periods
  localparam logic [4:0] CONV_HALVES = 5'h17; // 11.5 bit periods
  localparam logic [4:0] FIRST_BIT_HALF = 5'h03;
  localparam logic [4:0] LAST_BIT_HALF = 5'h15;
  localparam logic [4:0] WAIT_HALVES = 5'h04; // 2 bit periods
  // Result layout
  localparam int RESULT_W = 10;
  localparam int PAD_W = 6;
  localparam logic [3:0] MSB_IDX = 4'h9;
  // Reset values of control bits
  localparam logic [1:0] CSEL_RST = 2'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_WAIT} arsc_state_e;
endpackage

/* File: arsc_tick_if.sv */
// Carrier between the sequencer and the bit period timer
`timescale 1ns/10ps
interface arsc_tick_if;
  logic run;
  logic [1:0] csel;
  logic rc_tick;
  logic half_tick;
  modport timer (input run, input csel, input rc_tick, output half_tick);
  modport ctl (output run, output csel, output rc_tick, input half_tick);
endinterface

/* File: arsc_bit_timer.sv */
// Bit period timer: produces one pulse per half bit period
`timescale 1ns/10ps
module arsc_bit_timer
  import arsc_pkg::*;
(
  input wire logic clk_i,   // Oscillator clock
  input wire logic reset_i, // Synchronous reset
  arsc_tick_if.timer tk     // Timer side of the carrier
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic tick;
  logic next_tick;
  logic [3:0] term;

  // Divider per clock select, RC ticks pass through
  always_comb begin
    case (tk.csel)
      CSEL_2OSC: term = HALF_TERM_2OSC;
      CSEL_8OSC: term = HALF_TERM_8OSC;
      default: term = HALF_TERM_32OSC;
    endcase
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!tk.run) begin
      next_cnt = 4'h0; // Phase restarts with each run
    end else if (tk.csel == CSEL_RC) begin
      next_tick = tk.rc_tick;
    end else if (cnt == term) begin
      next_cnt = 4'h0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 4'h1;
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt <= 4'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  assign tk.half_tick = tick;
endmodule

/* File: arsc_analog_src.sv */
// Sampled analog input source seen by the converter comparator
`timescale 1ns/10ps
module arsc_analog_src (
  input wire logic clk_i,             // Oscillator clock
  input wire logic hold_connected_i,  // Hold capacitor on input
  input wire logic [9:0] level_i,     // Input level in steps of Vref/1024
  input wire logic [9:0] dac_code_i,  // Trial code
  output logic comparator_o           // Held level at or above trial
);
  logic [9:0] held;
  logic flip = 1'b0;
  // Track the input while connected; keep the sample once disconnected
  always @(posedge clk_i) begin
    flip <= ~flip;
    if (hold_connected_i) begin
      held <= level_i;
    end
  end
  // No valid decision while tracking, so show a changing pattern then
  assign comparator_o = hold_connected_i ? flip : (held >= dac_code_i);
endmodule

/* File: adc_result_sleep_control_tb.sv */
// Self-checking bench for the converter result and sleep control block
`timescale 1ns/10ps
module adc_result_sleep_control_tb;
  import arsc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr = 1'b0, on_d = 1'b0, js_d = 1'b0, ie_d = 1'b0, gs = 1'b0, gc = 1'b0, fc = 1'b0;
  logic hw = 1'b0, lw = 1'b0, sleep_i = 1'b0, rc = 1'b0, cmp;
  logic [1:0] cs_d = 2'h0, cs_o;
  logic [7:0] rc_div = 8'h00;
  logic [7:0] wd = 8'h00, hi, lo;
  logic [9:0] level = 10'h000, dac, v;
  logic on_o, js_o, ie_o, go, flag, wake, pwr, hold, woke;
  logic [15:0] prev;
  int n_fail = 0, n_checks = 0, cycles = 0, cyc, half;

  always #2.5 clk_i = ~clk_i;

  arsc_ctl dut_u (.clk_i(clk_i), .reset_i(reset_i), .ctl_wr_i(wr), .converter_on_i(on_d),
    .conv_clock_select_i(cs_d), .result_justify_select_i(js_d), .conv_done_irq_enable_i(ie_d),
    .go_set_i(gs), .go_clear_i(gc), .flag_clear_i(fc), .res_hi_wr_i(hw), .res_lo_wr_i(lw),
    .wdata_i(wd), .sleep_i(sleep_i), .rc_tick_i(rc), .comparator_i(cmp), .converter_on_o(on_o),
    .conv_clock_select_o(cs_o), .result_justify_select_o(js_o), .conv_done_irq_enable_o(ie_o),
    .go_done_o(go), .conv_done_flag_o(flag), .wake_o(wake), .converter_powered_o(pwr),
    .hold_connected_o(hold), .dac_code_o(dac), .result_high_byte_o(hi), .result_low_byte_o(lo));

  arsc_analog_src src_u (.clk_i(clk_i), .hold_connected_i(hold), .level_i(level),
    .dac_code_i(dac), .comparator_o(cmp));

  // RC clock runs free: a half-period tick every 160 cycles, so the bit period is 1.6 us.
  // Oscillator modes fall short of that at this clock; the input model has no droop.
  always @(posedge clk_i) begin
    #1;
    rc_div = (rc_div == 8'h9f) ? 8'h00 : rc_div + 8'h01;
    rc = (rc_div == 8'h00);
  end

  // Watchdog well above the longest expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] pair_of(input logic [9:0] r, input logic js);
    return js ? {6'h00, r} : {r, 6'h00};
  endfunction

  // Control write, done flag cleared alongside, then time for acquisition
  task automatic ctl(input logic on, input logic [1:0] cs, input logic js, input logic ie);
    wr = 1'b1;
    fc = 1'b1;
    {on_d, cs_d, js_d, ie_d} = {on, cs, js, ie};
    tick();
    wr = 1'b0;
    fc = 1'b0;
    tick(30);
  endtask

  task automatic go_pulse();
    gs = 1'b1;
    tick();
    gs = 1'b0;
  endtask

  // One conversion; the input moves once the hold is off, as a channel change would
  task automatic convert(input logic [9:0] x, input logic slp);
    level = x;
    woke = 1'b0;
    cyc = 0;
    go_pulse();
    sleep_i = slp;
    while (go === 1'b1 && cyc < 5000) begin
      if (hold === 1'b0) level = 10'($urandom);
      // Flag clear lands on the fastest completion edge: the set must win
      fc = (cyc == 42);
      tick();
      cyc++;
      woke = woke | (wake === 1'b1);
    end
    fc = 1'b0;
    tick();
    woke = woke | (wake === 1'b1);
  endtask

  initial begin
    void'($urandom(4));
    tick(10);
    reset_i = 1'b0;
    check("control", 16'h0, {6'h0, on_o, cs_o, js_o, ie_o, go, flag, wake, pwr, hold});
    hw = 1'b1;
    wd = 8'ha5;
    tick();
    hw = 1'b0;
    lw = 1'b1;
    wd = 8'h3c;
    tick();
    lw = 1'b0;
    tick();
    check("byte pair", 16'ha53c, {hi, lo});
    $display("test byte registers done");
    for (int cs = 0; cs < 3; cs++) begin
      for (int k = 0; k < 6; k++) begin
        v = (k == 0) ? 10'h000 : (k == 1) ? 10'h001 : (k == 2) ? 10'h3ff : 10'($urandom);
        ctl(1'b1, 2'(cs), k[0], 1'b0);
        convert(v, 1'b0);
        half = (cs == 0) ? 1 : (cs == 1) ? 4 : 16;
        check("start bit", 16'h0, {15'h0, go});
        check("done flag", 16'h1, {15'h0, flag});
        check("result", pair_of(v, k[0]), {hi, lo});
        check("wake", 16'h0, {15'h0, woke});
        check("length", 16'h1, {15'h0, cyc > 20 + 23 * half - 4 && cyc < 24 + 23 * half});
        tick(80);
      end
    end
    $display("test conversions done");
    for (int ie = 0; ie < 2; ie++) begin
      v = 10'($urandom);
      ctl(1'b1, CSEL_RC, 1'b1, ie[0]);
      convert(v, 1'b1);
      check("sleep result", pair_of(v, 1'b1), {hi, lo});
      check("wake", {15'h0, ie[0]}, {15'h0, woke});
      check("power on", {14'h0, ie[0], 1'b1}, {14'h0, pwr, on_o});
      sleep_i = 1'b0;
      // Post-completion wait lasts four RC half periods before a new start is taken
      tick(700);
    end
    $display("test rc sleep done");
    prev = {hi, lo};
    ctl(1'b1, CSEL_8OSC, 1'b0, 1'b1);
    go_pulse();
    tick(40);
    sleep_i = 1'b1;
    tick(300);
    check("sleep abort", {13'h0, 3'b001}, {13'h0, go, pwr, on_o});
    check("kept", prev, {hi, lo});
    check("no flag", 16'h0, {15'h0, flag});
    sleep_i = 1'b0;
    tick(3);
    check("repowered", 16'h1, {15'h0, pwr});
    $display("test sleep abort done");
    ctl(1'b1, CSEL_32OSC, 1'b0, 1'b0);
    go_pulse();
    tick(100);
    gc = 1'b1;
    tick();
    gc = 1'b0;
    go_pulse();
    tick();
    check("abort", 16'h0, {15'h0, go});
    check("kept", prev, {hi, lo});
    tick(100);
    v = 10'($urandom);
    convert(v, 1'b0);
    check("restart", pair_of(v, 1'b0), {hi, lo});
    $display("test abort done");
    prev = {hi, lo};
    ctl(1'b1, CSEL_2OSC, 1'b1, 1'b1);
    go_pulse();
    tick(30);
    reset_i = 1'b1;
    tick();
    reset_i = 1'b0;
    check("control", 16'h0, {6'h0, on_o, cs_o, js_o, ie_o, go, flag, wake, pwr, hold});
    check("kept", prev, {hi, lo});
    $display("test reset done");
    complete_run();
  end
endmodule
